// ===== common/tw_pkg.sv
// constants, register map, status codes and states of the two-wire block
package tw_pkg;
  // ----------------------------------------------------------------
  // register addresses and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hAA;
  localparam logic [7:0] STAT_ADDR = 8'hAB;
  localparam logic [7:0] OWN_ADDR = 8'hAC;
  localparam logic [7:0] DATA_ADDR = 8'hAD;
  localparam int ON_BIT = 6;
  localparam int BEGIN_BIT = 5;
  localparam int HALT_BIT = 4;
  localparam int ATT_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int BCAST_BIT = 0;
  localparam logic [7:0] OWN_RESET = 8'hFE;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [6:0] BROADCAST_ADDRESS = 7'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // ----------------------------------------------------------------
  // status codes, low three bits always zero
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_NOINFO = 8'hF8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RESTART = 8'h10;
  localparam logic [7:0] CODE_MT_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_MT_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_MT_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_MT_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_MR_ADDR_ACK = 8'h40;
  localparam logic [7:0] CODE_MR_ADDR_NACK = 8'h48;
  localparam logic [7:0] CODE_MR_DATA_ACK = 8'h50;
  localparam logic [7:0] CODE_MR_DATA_NACK = 8'h58;
  localparam logic [7:0] CODE_SL_RX_ADDR = 8'h60;
  localparam logic [7:0] CODE_SL_BCAST = 8'h70;
  localparam logic [7:0] CODE_SL_RX_DATA = 8'h80;
  localparam logic [7:0] CODE_SL_RX_NACK = 8'h88;
  localparam logic [7:0] CODE_SL_STOP = 8'hA0;
  localparam logic [7:0] CODE_SL_TX_ADDR = 8'hA8;
  localparam logic [7:0] CODE_SL_TX_DATA = 8'hB8;
  localparam logic [7:0] CODE_SL_TX_NACK = 8'hC0;
  localparam logic [7:0] CODE_BUS_ERR = 8'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS = 5000;
  localparam logic [9:0] SCL_HALF_CYC =
    10'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // protocol states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_RS_A, ST_RS_B, ST_START, ST_WAIT, ST_LOW, ST_HIGH,
    ST_STOP_A, ST_STOP_B, ST_STOP_C, ST_SLAVE
  } state_type;
endpackage

// ===== logic/two_wire_ctrl_status_addr.sv
// control, status and own-address logic of the two-wire serial unit
`timescale 1ns/1ps
// What this block does
// R1: unit works only while enable bit set
// R2: begin request makes start; software clears it
// R3: halt request makes stop; hardware clears it
// R4: hardware sets attention flag on each event
// R5: software alone clears the attention flag
// R6: attention flag holds clock line low
// R7: clearing attention launches next bus operation
// R8: software finishes register accesses before clearing
// R9: receiver with ack bit clear sends nack
// R10: receiver with ack bit set drives ack
// R11: ack bit clear ignores own and broadcast
// R12: ack bit ignored in master transmitter mode
// R13: status code in upper five bits
// R14: status meaningful only while attention set
// R15: slave answers only its seven-bit address, or broadcast when R16 enables it
// R16: broadcast enable bit allows all-zero address
// R17: status shows code after attention, else none
// R18: attention raised on listed bus events
// R19: data writes ignored while attention clear
// R20: disabling releases lines and idles machine
module two_wire_ctrl_status_addr (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tw_pkg::state_type st_q, st_d;
  logic iface_q, iface_d, begin_q, begin_d, halt_q, halt_d;
  logic att_q, att_d, ack_q, ack_d;
  logic [7:0] own_q, own_d, stat_q, stat_d, code_q, code_d;
  logic [7:0] shreg_q, shreg_d, rdata_q, rdata_d, new_code;
  logic [3:0] cnt_q, cnt_d;
  logic [9:0] tmr_q, tmr_d;
  logic master_q, master_d, tx_q, tx_d, addr_ph_q, addr_ph_d;
  logic addressed_q, addressed_d, busy_q, busy_d;
  logic done_q, done_d, ack_seen_q, ack_seen_d;
  logic mscl_q, mscl_d, sda_low_q, sda_low_d;
  logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d, level_q;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic wr_ctrl, wr_own, wr_data, set_att, tdone;
  logic rise, fall, start_det, stop_det;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // data bit or ack slot level; a transmitter never drives the ack slot
  function automatic logic drive_low(input logic [3:0] cnt,
                                     input logic tx, input logic msb,
                                     input logic ack);
    drive_low = (cnt < tw_pkg::ACK_SLOT) ? (tx & ~msb) : (~tx & ack);
  endfunction

  function automatic logic addr_hit(input logic [7:0] rx,
                                    input logic [7:0] own);
    addr_hit = (rx[7:1] == own[7:1]) ||
               (own[tw_pkg::BCAST_BIT] &&
                rx[7:1] == tw_pkg::BROADCAST_ADDRESS);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // the third stage only feeds edge detection of the second
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
    end
  end

  assign wr_ctrl = sfr_wr_in && sfr_addr_in == tw_pkg::CTRL_ADDR;
  assign wr_own = sfr_wr_in && sfr_addr_in == tw_pkg::OWN_ADDR;
  assign wr_data = sfr_wr_in && sfr_addr_in == tw_pkg::DATA_ADDR;
  assign tdone = tmr_q == 10'h000;
  assign rise = scl_s_q & ~scl_p_q;
  assign fall = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    iface_d = iface_q;
    begin_d = begin_q;
    halt_d = halt_q;
    att_d = att_q;
    ack_d = ack_q;
    own_d = own_q;
    code_d = code_q;
    shreg_d = shreg_q;
    cnt_d = cnt_q;
    master_d = master_q;
    tx_d = tx_q;
    addr_ph_d = addr_ph_q;
    addressed_d = addressed_q;
    done_d = done_q;
    ack_seen_d = ack_seen_q;
    mscl_d = mscl_q;
    sda_low_d = sda_low_q;
    set_att = 1'b0;
    new_code = code_q;
    tmr_d = tdone ? 10'h000 : tmr_q - 10'h001;
    busy_d = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);
    if (wr_ctrl) begin
      iface_d = sfr_wdata_in[tw_pkg::ON_BIT]; // R1
      begin_d = sfr_wdata_in[tw_pkg::BEGIN_BIT]; // R2
      halt_d = sfr_wdata_in[tw_pkg::HALT_BIT];
      ack_d = sfr_wdata_in[tw_pkg::ACK_BIT];
      if (!sfr_wdata_in[tw_pkg::ATT_BIT]) begin
        att_d = 1'b0;
      end
    end
    if (wr_own) begin
      own_d = sfr_wdata_in;
    end
    if (wr_data && att_q) begin
      shreg_d = sfr_wdata_in; // R19
    end
    case (st_q)
      tw_pkg::ST_IDLE: begin
        mscl_d = 1'b0;
        sda_low_d = 1'b0;
        master_d = 1'b0;
        if (start_det) begin
          st_d = tw_pkg::ST_SLAVE;
          cnt_d = 4'h0;
          addr_ph_d = 1'b1;
          tx_d = 1'b0;
        end else if (begin_q && !att_q && !busy_q) begin // R2
          st_d = tw_pkg::ST_START;
          sda_low_d = 1'b1;
          master_d = 1'b1;
          addr_ph_d = 1'b0;
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end
      end
      tw_pkg::ST_RS_A: if (tdone) begin
        mscl_d = 1'b0;
        st_d = tw_pkg::ST_RS_B;
        tmr_d = tw_pkg::SCL_HALF_CYC;
      end
      tw_pkg::ST_RS_B: begin
        if (!scl_s_q) begin
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end else if (tdone) begin
          sda_low_d = 1'b1;
          st_d = tw_pkg::ST_START;
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end
      end
      tw_pkg::ST_START: if (tdone) begin
        mscl_d = 1'b1;
        st_d = tw_pkg::ST_WAIT;
        set_att = 1'b1; // R18
        new_code = addr_ph_q ? tw_pkg::CODE_RESTART : tw_pkg::CODE_START;
        addr_ph_d = 1'b1;
        tx_d = 1'b1;
        cnt_d = 4'h0;
      end
      tw_pkg::ST_WAIT: if (!att_q) begin // R7
        if (!master_q) begin
          if (halt_q || !(addressed_q || addr_ph_q)) begin
            halt_d = 1'b0;
            addressed_d = 1'b0;
            st_d = tw_pkg::ST_IDLE;
          end else begin
            st_d = tw_pkg::ST_SLAVE;
            cnt_d = 4'h0;
            sda_low_d = tx_q & ~shreg_q[7];
          end
        end else if (halt_q) begin
          st_d = tw_pkg::ST_STOP_A;
          sda_low_d = 1'b1;
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end else if (begin_q) begin
          st_d = tw_pkg::ST_RS_A;
          sda_low_d = 1'b0;
          addr_ph_d = 1'b1;
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end else begin
          st_d = tw_pkg::ST_LOW;
          cnt_d = 4'h0;
          sda_low_d = drive_low(4'h0, tx_q, shreg_q[7], ack_q);
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end
      end
      tw_pkg::ST_LOW: if (tdone) begin
        mscl_d = 1'b0;
        st_d = tw_pkg::ST_HIGH;
        tmr_d = tw_pkg::SCL_HALF_CYC;
      end
      tw_pkg::ST_HIGH: begin
        // a slow slave or another master keeps us waiting here
        if (!scl_s_q) begin
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end else if (tdone && cnt_q < tw_pkg::ACK_SLOT) begin
          if (tx_q && !sda_low_q && !sda_s_q) begin
            master_d = 1'b0;
            addr_ph_d = 1'b0;
            sda_low_d = 1'b0;
            st_d = tw_pkg::ST_WAIT;
            set_att = 1'b1; // R18
            new_code = tw_pkg::CODE_ARB_LOST;
          end else begin
            shreg_d = {shreg_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
            mscl_d = 1'b1;
            st_d = tw_pkg::ST_LOW;
            tmr_d = tw_pkg::SCL_HALF_CYC;
            // R9 R10 R12
            sda_low_d = drive_low(cnt_q + 4'h1, tx_q, shreg_q[6], ack_q);
          end
        end else if (tdone) begin
          mscl_d = 1'b1;
          st_d = tw_pkg::ST_WAIT;
          set_att = 1'b1; // R18
          addr_ph_d = 1'b0;
          if (addr_ph_q) begin
            tx_d = ~shreg_q[0];
            if (shreg_q[0]) begin
              new_code = sda_s_q ? tw_pkg::CODE_MR_ADDR_NACK
                                 : tw_pkg::CODE_MR_ADDR_ACK;
            end else begin
              new_code = sda_s_q ? tw_pkg::CODE_MT_ADDR_NACK
                                 : tw_pkg::CODE_MT_ADDR_ACK;
            end
          end else if (tx_q) begin
            new_code = sda_s_q ? tw_pkg::CODE_MT_DATA_NACK
                               : tw_pkg::CODE_MT_DATA_ACK;
          end else begin
            new_code = sda_low_q ? tw_pkg::CODE_MR_DATA_ACK
                                 : tw_pkg::CODE_MR_DATA_NACK;
          end
        end
      end
      tw_pkg::ST_STOP_A: if (tdone) begin
        mscl_d = 1'b0;
        st_d = tw_pkg::ST_STOP_B;
        tmr_d = tw_pkg::SCL_HALF_CYC;
      end
      tw_pkg::ST_STOP_B: begin
        if (!scl_s_q) begin
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end else if (tdone) begin
          sda_low_d = 1'b0;
          st_d = tw_pkg::ST_STOP_C;
          tmr_d = tw_pkg::SCL_HALF_CYC;
        end
      end
      tw_pkg::ST_STOP_C: if (tdone) begin
        halt_d = 1'b0; // R3
        master_d = 1'b0;
        st_d = tw_pkg::ST_IDLE;
      end
      tw_pkg::ST_SLAVE: begin
        if (start_det || stop_det) begin
          sda_low_d = 1'b0;
          if (cnt_q != 4'h0 || done_q) begin
            set_att = 1'b1; // R18
            new_code = tw_pkg::CODE_BUS_ERR;
            addressed_d = 1'b0;
            addr_ph_d = 1'b0;
            done_d = 1'b0;
            st_d = tw_pkg::ST_WAIT;
          end else if (addressed_q) begin
            set_att = 1'b1; // R18
            new_code = tw_pkg::CODE_SL_STOP;
            addressed_d = 1'b0;
            addr_ph_d = start_det;
            tx_d = 1'b0;
            st_d = tw_pkg::ST_WAIT;
          end else if (start_det) begin
            addr_ph_d = 1'b1;
          end else begin
            st_d = tw_pkg::ST_IDLE;
          end
        end else if (rise) begin
          if (cnt_q < tw_pkg::ACK_SLOT) begin
            shreg_d = {shreg_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else begin
            cnt_d = 4'h0;
            done_d = 1'b1;
            ack_seen_d = ~sda_s_q;
          end
        end else if (fall && done_q) begin
          done_d = 1'b0;
          sda_low_d = 1'b0;
          if (!addressed_q) begin
            st_d = tw_pkg::ST_IDLE;
          end else begin
            set_att = 1'b1; // R18
            st_d = tw_pkg::ST_WAIT;
            addr_ph_d = 1'b0;
            if (addr_ph_q) begin
              new_code = tx_q ? tw_pkg::CODE_SL_TX_ADDR :
                (shreg_q[7:1] == tw_pkg::BROADCAST_ADDRESS) ?
                tw_pkg::CODE_SL_BCAST : tw_pkg::CODE_SL_RX_ADDR;
            end else if (tx_q) begin
              new_code = ack_seen_q ? tw_pkg::CODE_SL_TX_DATA
                                    : tw_pkg::CODE_SL_TX_NACK;
              addressed_d = ack_seen_q;
            end else begin
              new_code = sda_low_q ? tw_pkg::CODE_SL_RX_DATA
                                   : tw_pkg::CODE_SL_RX_NACK;
            end
          end
        end else if (fall && cnt_q == tw_pkg::ACK_SLOT && addr_ph_q) begin
          if (ack_q && addr_hit(shreg_q, own_q)) begin // R11 R15 R16
            addressed_d = 1'b1;
            tx_d = shreg_q[0] &&
                   shreg_q[7:1] != tw_pkg::BROADCAST_ADDRESS;
            sda_low_d = 1'b1;
          end else begin
            st_d = tw_pkg::ST_IDLE;
          end
        end else if (fall) begin
          sda_low_d = drive_low(cnt_q, tx_q, shreg_q[7], ack_q); // R9 R10
        end
      end
      default: st_d = tw_pkg::ST_IDLE;
    endcase
    if (!iface_q) begin // R20
      st_d = tw_pkg::ST_IDLE;
      mscl_d = 1'b0;
      sda_low_d = 1'b0;
      master_d = 1'b0;
      addressed_d = 1'b0;
      done_d = 1'b0;
      set_att = 1'b0;
    end
    // a new event wins over a software clear in the same cycle
    if (set_att) begin
      att_d = 1'b1; // R4
      code_d = new_code;
    end
    stat_d = att_q ? code_q : tw_pkg::CODE_NOINFO; // R17 R13
    scl_oe_n_d = !(iface_d && (att_d || mscl_d)); // R6
    sda_oe_n_d = !(iface_d && sda_low_d);
    case (sfr_addr_in)
      tw_pkg::CTRL_ADDR: rdata_d = {1'b0, iface_q, begin_q, halt_q,
                                    att_q, ack_q, 2'b00};
      tw_pkg::STAT_ADDR: rdata_d = {stat_q[7:3], 3'b000}; // R13
      tw_pkg::OWN_ADDR: rdata_d = own_q;
      tw_pkg::DATA_ADDR: rdata_d = shreg_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= tw_pkg::ST_IDLE;
      {iface_q, begin_q, halt_q, att_q, ack_q} <= 5'h00;
      own_q <= tw_pkg::OWN_RESET;
      stat_q <= tw_pkg::CODE_NOINFO;
      code_q <= tw_pkg::CODE_NOINFO;
      shreg_q <= tw_pkg::DATA_RESET;
      rdata_q <= 8'h00;
      cnt_q <= 4'h0;
      tmr_q <= 10'h000;
      {master_q, tx_q, addr_ph_q, addressed_q, busy_q} <= 5'h00;
      {done_q, ack_seen_q, mscl_q, sda_low_q} <= 4'h0;
      {scl_oe_n_q, sda_oe_n_q, level_q} <= 3'h6;
    end else begin
      st_q <= st_d;
      {iface_q, begin_q, halt_q, att_q, ack_q} <=
        {iface_d, begin_d, halt_d, att_d, ack_d};
      own_q <= own_d;
      stat_q <= stat_d;
      code_q <= code_d;
      shreg_q <= shreg_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      {master_q, tx_q, addr_ph_q, addressed_q, busy_q} <=
        {master_d, tx_d, addr_ph_d, addressed_d, busy_d};
      {done_q, ack_seen_q, mscl_q, sda_low_q} <=
        {done_d, ack_seen_d, mscl_d, sda_low_d};
      {scl_oe_n_q, sda_oe_n_q, level_q} <= {scl_oe_n_d, sda_oe_n_d, 1'b0};
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign scl_oe_n_out = scl_oe_n_q;
  assign sda_oe_n_out = sda_oe_n_q;
  assign scl_out = level_q;
  assign sda_out = level_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic ack_edge;
  assign ack_edge = st_q == tw_pkg::ST_HIGH && st_d == tw_pkg::ST_LOW &&
                    cnt_d == tw_pkg::ACK_SLOT && !wr_ctrl && iface_q;

  status_low_zero_a: assert property (stat_q[2:0] == 3'b000)
    else $error("status low bits not zero"); // R13
  status_code_a: assert property ($rose(att_q) |=> // R17
    stat_q == $past(code_q)) else $error("status not updated");
  status_none_a: assert property (!att_q && !$past(att_q) |-> // R17
    stat_q == tw_pkg::CODE_NOINFO) else $error("status not idle code");
  clock_stretch_a: assert property (att_q && iface_q |-> // R6
    !scl_oe_n_out) else $error("clock not held during attention");
  off_release_a: assert property (!iface_q |-> // R20
    scl_oe_n_out && sda_oe_n_out) else $error("lines driven when off");
  begin_kept_a: assert property (begin_q && !wr_ctrl |=> // R2
    begin_q) else $error("begin request cleared by hardware");
  att_kept_a: assert property (att_q && !wr_ctrl |=> // R5
    att_q) else $error("attention cleared without software");
  data_ignored_a: assert property (wr_data && !att_q && // R19
    st_q == tw_pkg::ST_IDLE |=> $stable(shreg_q))
    else $error("data write taken without attention");
  rx_nack_a: assert property (ack_edge && !tx_q && !ack_q |=> // R9
    sda_oe_n_out) else $error("nack slot driven");
  rx_ack_a: assert property (ack_edge && !tx_q && ack_q |=> // R10
    !sda_oe_n_out) else $error("ack slot not driven");
  tx_ack_free_a: assert property (ack_edge && tx_q |=> // R12
    sda_oe_n_out) else $error("transmitter drove ack slot");
  halt_clear_a: assert property (st_q == tw_pkg::ST_STOP_C && // R3
    st_d == tw_pkg::ST_IDLE |=> !halt_q)
    else $error("halt request not cleared after stop");
  start_sent_c: cover property (st_q == tw_pkg::ST_START ##1
    st_q == tw_pkg::ST_WAIT);
  stop_sent_c: cover property (st_q == tw_pkg::ST_STOP_C ##1
    st_q == tw_pkg::ST_IDLE);
  slave_hit_c: cover property ($rose(addressed_q));
  arb_lost_c: cover property (att_q && code_q == tw_pkg::CODE_ARB_LOST);
endmodule

// ===== tb/tw_peer_slave.sv
// behavioural slave on the two-wire bus that acks its own address
`timescale 1ns/1ps
module tw_peer_slave #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_low_out
);
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  logic hit = 1'b0;
  initial sda_low_out = 1'b0;
  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    cnt = 0;
    hit = 1'b0;
  end
  always @(posedge sda_in) if (scl_in === 1'b1) hit = 1'b0;
  always @(posedge scl_in) begin
    sh = {sh[6:0], sda_in};
    cnt++;
  end
  // ack only while the address matched; acks every later byte too
  always @(negedge scl_in) begin
    if (cnt == 8 && (hit || sh[7:1] == ADDR)) begin
      hit = 1'b1;
      sda_low_out = 1'b1;
    end else if (cnt >= 9) begin
      sda_low_out = 1'b0;
      cnt = 0;
    end
  end
endmodule

// ===== tb/two_wire_ctrl_status_addr_test.sv
// self-checking bench for the two-wire control, status and address block
`timescale 1ns/1ps
module two_wire_ctrl_status_addr_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, peer_low;
  int num_errors = 0;
  int num_checks = 0;
  // open-drain lines with pull-ups
  wire logic scl_w = scl_oe_n_out | scl_out;
  // data line settles just after the clock line, so a data change made in
  // the same cycle as a clock fall never looks like a start or stop
  wire logic sda_w;
  assign #1 sda_w = (sda_oe_n_out | sda_out) & ~peer_low;
  always #5 clk_in = ~clk_in;
  two_wire_ctrl_status_addr i_two_wire_ctrl_status_addr (
    .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n_out(scl_oe_n_out), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out));
  tw_peer_slave #(.ADDR(7'h50)) i_tw_peer_slave (
    .scl_in(scl_w), .sda_in(sda_w), .sda_low_out(peer_low));
  // ----------------------------------------------------------------
  // register access and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge clk_in);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_in);
    sfr_addr_in = a;
    @(negedge clk_in);
    v = sfr_rdata_out;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // bounded poll of one control bit; a byte takes about 9000 cycles
  task automatic wait_ctrl(input int b, input logic val);
    logic [7:0] v;
    for (int n = 0; n < 8000; n++) begin
      rd(tw_pkg::CTRL_ADDR, v);
      if (v[b] === val) return;
    end
    num_errors++;
    $display("BAD %0t control bit wait ran out", $time);
    give_verdict();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk_in);
    reset_in = 1'b0;
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_NOINFO);
    chk_rd(tw_pkg::OWN_ADDR, tw_pkg::OWN_RESET);
    chk_rd(tw_pkg::CTRL_ADDR, 8'h00);
    wr(tw_pkg::OWN_ADDR, 8'h33);
    chk_rd(tw_pkg::OWN_ADDR, 8'h33);
    wr(tw_pkg::DATA_ADDR, 8'h55);
    chk_rd(tw_pkg::DATA_ADDR, tw_pkg::DATA_RESET);
    // begin request without enable must leave the bus alone
    wr(tw_pkg::CTRL_ADDR, 8'h24);
    repeat (1200) @(negedge clk_in);
    chk({6'h00, scl_oe_n_out, sda_oe_n_out}, 8'h03);
    wr(tw_pkg::CTRL_ADDR, 8'h64);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_START);
    chk_rd(tw_pkg::CTRL_ADDR, 8'h6C);
    chk({7'h00, scl_oe_n_out}, 8'h00);
    wr(tw_pkg::DATA_ADDR, 8'hA0);
    chk_rd(tw_pkg::DATA_ADDR, 8'hA0);
    wr(tw_pkg::CTRL_ADDR, 8'h44);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_MT_ADDR_ACK);
    // ack bit clear must not matter while transmitting
    wr(tw_pkg::DATA_ADDR, 8'h3C);
    wr(tw_pkg::CTRL_ADDR, 8'h40);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_MT_DATA_ACK);
    // repeated start, then read two bytes: first acked, then refused
    wr(tw_pkg::CTRL_ADDR, 8'h64);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_RESTART);
    wr(tw_pkg::DATA_ADDR, 8'hA1);
    wr(tw_pkg::CTRL_ADDR, 8'h44);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_MR_ADDR_ACK);
    wr(tw_pkg::CTRL_ADDR, 8'h44);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_MR_DATA_ACK);
    chk_rd(tw_pkg::DATA_ADDR, 8'hFF);
    wr(tw_pkg::CTRL_ADDR, 8'h40);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_MR_DATA_NACK);
    wr(tw_pkg::CTRL_ADDR, 8'h50);
    wait_ctrl(tw_pkg::HALT_BIT, 1'b0);
    chk_rd(tw_pkg::STAT_ADDR, tw_pkg::CODE_NOINFO);
    chk_rd(tw_pkg::CTRL_ADDR, 8'h40);
    chk({6'h00, scl_w, sda_w}, 8'h03);
    // disable while the flag holds the clock low
    wr(tw_pkg::CTRL_ADDR, 8'h64);
    wait_ctrl(tw_pkg::ATT_BIT, 1'b1);
    wr(tw_pkg::CTRL_ADDR, 8'h2C);
    repeat (4) @(negedge clk_in);
    chk({6'h00, scl_oe_n_out, sda_oe_n_out}, 8'h03);
    give_verdict();
  end
endmodule
